// *** core/swrid_core.v ***
// Slave-side single-wire identity and add-only memory front end.
// Assumes a slot decoder on the same clock that reports each time slot and
// each bus reset as one-cycle pulses; the programming-voltage sense is a pin.
`timescale 1ns/10ps
`include "swrid_map.vh"

module swrid_core #(
    parameter [7:0] FAMILY_CODE = `SWRID_FAMILY_DEFAULT,
    parameter [47:0] SERIAL_NUM = `SWRID_SERIAL_DEFAULT
) (
    input wire CORE_CLK_I,
    input wire RESET_N_I,
    input wire BUS_RESET_I,
    input wire SLOT_I,
    input wire SLOT_BIT_I,
    input wire PROG_SENSE_I,
    output reg TX_BIT_O,
    output reg PROG_DETECT_O,
    output reg ROM_DONE_O
);
    // ---------------------------------------------------------------
    // CRC helpers
    // ---------------------------------------------------------------
    function [7:0] crc_bit;
        input [7:0] c;
        input b;
        begin
            crc_bit = {1'b0, c[7:1]} ^ ((c[0] ^ b) ? `SWRID_CRC_POLY : 8'h00);
        end
    endfunction

    function [7:0] crc_byte;
        input [7:0] c;
        input [7:0] d;
        integer k;
        reg [7:0] r;
        begin
            r = c;
            for (k = 0; k < 8; k = k + 1) begin
                r = crc_bit(r, d[k]);
            end
            crc_byte = r;
        end
    endfunction

    function [7:0] crc_id;
        input [55:0] v;
        integer k;
        reg [7:0] r;
        begin
            r = `SWRID_CRC_INIT;
            for (k = 0; k < 56; k = k + 1) begin
                r = crc_bit(r, v[k]);
            end
            crc_id = r;
        end
    endfunction

    // Check byte sits on top, so shifting all 64 bits ends at zero
    localparam [7:0] ID_CRC = crc_id({SERIAL_NUM, FAMILY_CODE});
    localparam [63:0] ID_BITS = {ID_CRC, SERIAL_NUM, FAMILY_CODE};

    // ---------------------------------------------------------------
    // States
    // ---------------------------------------------------------------
    localparam [3:0] ST_ROM_CMD = 4'h0;
    localparam [3:0] ST_ID_TX = 4'h1;
    localparam [3:0] ST_MATCH = 4'h2;
    localparam [3:0] ST_SEARCH = 4'h3;
    localparam [3:0] ST_MEM_CMD = 4'h4;
    localparam [3:0] ST_ADDR = 4'h5;
    localparam [3:0] ST_RD_DATA = 4'h6;
    localparam [3:0] ST_WR_DATA = 4'h7;
    localparam [3:0] ST_WR_PUSH = 4'h8;
    localparam [3:0] ST_WR_PROG = 4'h9;
    localparam [3:0] ST_DEAD = 4'hA;

    reg [3:0] state_q;
    reg [7:0] rx_sr_q;
    reg [2:0] rx_cnt_q;
    reg [5:0] idx_q;
    reg [1:0] step_q;
    reg [1:0] sub_q;
    reg [7:0] cmd_q;
    reg [15:0] addr_q;
    reg addr_hi_q;
    reg [7:0] data_q;
    reg [7:0] echo_q;
    reg [7:0] crc_q;
    reg [7:0] tx_sr_q;
    reg [3:0] tx_cnt_q;
    reg [3:0] prot_q;
    reg [7:0] mem_q [0:`SWRID_MEM_BYTES-1];
    reg sync1_q;
    reg prog_prev_q;
    integer i;

    wire rx_state;
    wire byte_done;
    wire [7:0] rx_byte;
    wire tx_busy;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire drained;
    wire in_range;
    wire prog_edge;
    wire id_bit;
    wire page_open;
    reg push_valid;
    reg [7:0] push_data;
    wire push_fire;

    assign rx_state = (state_q == ST_ROM_CMD) || (state_q == ST_MEM_CMD) ||
                      (state_q == ST_ADDR) || (state_q == ST_WR_DATA);
    assign byte_done = SLOT_I && rx_state && (rx_cnt_q == 3'h7);
    assign rx_byte = {SLOT_BIT_I, rx_sr_q[7:1]};
    assign tx_busy = (tx_cnt_q != 4'h0);
    assign drained = !fifo_out_valid && !tx_busy;
    assign in_range = (addr_q < `SWRID_MEM_END);
    assign prog_edge = PROG_DETECT_O && !prog_prev_q;
    assign id_bit = ID_BITS[idx_q];
    assign page_open = prot_q[addr_q[`SWRID_PAGE_MSB:`SWRID_PAGE_LSB]];
    assign push_fire = push_valid && fifo_in_ready;

    // ---------------------------------------------------------------
    // Programming-voltage sense
    // ---------------------------------------------------------------
    // Pin is asynchronous; only the second stage and its one-cycle delayed copy feed any logic
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sync1_q <= 1'b0;
            PROG_DETECT_O <= 1'b0;
            prog_prev_q <= 1'b0;
        end else begin
            sync1_q <= PROG_SENSE_I;
            PROG_DETECT_O <= sync1_q;
            prog_prev_q <= PROG_DETECT_O;
        end
    end

    // ---------------------------------------------------------------
    // Byte producer into the FIFO
    // ---------------------------------------------------------------
    always @* begin
        push_valid = 1'b0;
        push_data = 8'h00;
        case (state_q)
            ST_ID_TX: begin
                push_valid = (idx_q[3:0] != `SWRID_ID_BYTES);
                push_data = ID_BITS[{idx_q[2:0], 3'b000} +: 8];
            end
            ST_RD_DATA: begin
                push_valid = (sub_q != 2'h2);
                push_data = (sub_q == 2'h1 && in_range) ? mem_q[addr_q[6:0]] : crc_q;
            end
            ST_WR_PUSH: begin
                push_valid = (sub_q != 2'h2);
                push_data = (sub_q == 2'h0) ? crc_q : echo_q;
            end
            default: begin
                push_valid = 1'b0;
                push_data = 8'h00;
            end
        endcase
    end

    swrid_fifo #(
        .WIDTH(`SWRID_FIFO_WIDTH),
        .DEPTH(`SWRID_FIFO_DEPTH),
        .AW(`SWRID_FIFO_AW)
    ) u_fifo (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESET_N_I),
        .flush_i(BUS_RESET_I),
        .in_valid_i(push_valid),
        .in_data_i(push_data),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out_data),
        .out_ready_i(!tx_busy)
    );

    // ---------------------------------------------------------------
    // Bit transmitter
    // ---------------------------------------------------------------
    // Idle slots read as one because the device simply leaves the line released
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tx_sr_q <= 8'hFF;
            tx_cnt_q <= 4'h0;
            TX_BIT_O <= 1'b1;
        end else begin
            if (BUS_RESET_I) begin
                tx_cnt_q <= 4'h0;
            end else if (!tx_busy && fifo_out_valid) begin
                tx_sr_q <= fifo_out_data;
                tx_cnt_q <= 4'h8;
            end else if (SLOT_I && tx_busy && !rx_state && state_q != ST_SEARCH) begin
                tx_sr_q <= {1'b1, tx_sr_q[7:1]};
                tx_cnt_q <= tx_cnt_q - 4'h1;
            end
            if (state_q == ST_SEARCH && step_q != 2'h2) begin
                TX_BIT_O <= id_bit ^ step_q[0];
            end else if (tx_busy && !BUS_RESET_I) begin
                TX_BIT_O <= tx_sr_q[0];
            end else begin
                TX_BIT_O <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Command sequencer and memory
    // ---------------------------------------------------------------
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q <= ST_ROM_CMD;
            rx_sr_q <= 8'h00;
            rx_cnt_q <= 3'h0;
            idx_q <= 6'h00;
            step_q <= 2'h0;
            sub_q <= 2'h0;
            cmd_q <= 8'h00;
            addr_q <= 16'h0000;
            addr_hi_q <= 1'b0;
            data_q <= 8'h00;
            echo_q <= 8'h00;
            crc_q <= `SWRID_CRC_INIT;
            prot_q <= `SWRID_PROT_RESET;
            ROM_DONE_O <= 1'b0;
            for (i = 0; i < `SWRID_MEM_BYTES; i = i + 1) begin
                mem_q[i] <= `SWRID_ERASED;
            end
        end else if (BUS_RESET_I) begin
            state_q <= ST_ROM_CMD;
            rx_cnt_q <= 3'h0;
            ROM_DONE_O <= 1'b0;
        end else begin
            if (SLOT_I && rx_state) begin
                rx_sr_q <= rx_byte;
                rx_cnt_q <= rx_cnt_q + 3'h1;
            end
            case (state_q)
                ST_ROM_CMD: begin
                    if (byte_done) begin
                        idx_q <= 6'h00;
                        step_q <= 2'h0;
                        case (rx_byte)
                            `SWRID_ROM_READ: state_q <= ST_ID_TX;
                            `SWRID_ROM_MATCH: state_q <= ST_MATCH;
                            `SWRID_ROM_SEARCH: state_q <= ST_SEARCH;
                            `SWRID_ROM_SKIP: begin
                                state_q <= ST_MEM_CMD;
                                ROM_DONE_O <= 1'b1;
                            end
                            default: state_q <= ST_DEAD;
                        endcase
                    end
                end
                ST_ID_TX: begin
                    if (push_fire) begin
                        idx_q <= idx_q + 6'h01;
                    end else if (!push_valid && drained) begin
                        state_q <= ST_MEM_CMD;
                        ROM_DONE_O <= 1'b1;
                    end
                end
                ST_MATCH: begin
                    if (SLOT_I) begin
                        if (SLOT_BIT_I != id_bit) begin
                            state_q <= ST_DEAD;
                        end else if (idx_q == `SWRID_ID_LAST_BIT) begin
                            state_q <= ST_MEM_CMD;
                            ROM_DONE_O <= 1'b1;
                        end else begin
                            idx_q <= idx_q + 6'h01;
                        end
                    end
                end
                ST_SEARCH: begin
                    if (SLOT_I) begin
                        if (step_q != 2'h2) begin
                            step_q <= step_q + 2'h1;
                        end else begin
                            step_q <= 2'h0;
                            if (SLOT_BIT_I != id_bit) begin
                                state_q <= ST_DEAD;
                            end else if (idx_q == `SWRID_ID_LAST_BIT) begin
                                state_q <= ST_MEM_CMD;
                                ROM_DONE_O <= 1'b1;
                            end else begin
                                idx_q <= idx_q + 6'h01;
                            end
                        end
                    end
                end
                ST_MEM_CMD: begin
                    // Only reachable through a finished ROM command
                    if (byte_done) begin
                        cmd_q <= rx_byte;
                        crc_q <= crc_byte(`SWRID_CRC_INIT, rx_byte);
                        addr_hi_q <= 1'b0;
                        if (rx_byte == `SWRID_CMD_READ_MEM || rx_byte == `SWRID_CMD_WRITE_MEM ||
                            rx_byte == `SWRID_CMD_WRITE_PROT) begin
                            state_q <= ST_ADDR;
                        end else begin
                            state_q <= ST_DEAD;
                        end
                    end
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        crc_q <= crc_byte(crc_q, rx_byte);
                        addr_hi_q <= 1'b1;
                        if (!addr_hi_q) begin
                            addr_q[7:0] <= rx_byte;
                        end else begin
                            addr_q[15:8] <= rx_byte;
                            sub_q <= 2'h0;
                            state_q <= (cmd_q == `SWRID_CMD_READ_MEM) ? ST_RD_DATA : ST_WR_DATA;
                        end
                    end
                end
                ST_RD_DATA: begin
                    if (push_fire) begin
                        if (sub_q == 2'h0) begin
                            sub_q <= 2'h1;
                            crc_q <= `SWRID_CRC_INIT;
                        end else if (in_range) begin
                            crc_q <= crc_byte(crc_q, mem_q[addr_q[6:0]]);
                            addr_q <= addr_q + 16'h0001;
                        end else begin
                            sub_q <= 2'h2;
                            state_q <= ST_DEAD;
                        end
                    end
                end
                ST_WR_DATA: begin
                    if (byte_done) begin
                        data_q <= rx_byte;
                        crc_q <= crc_byte(crc_q, rx_byte);
                        sub_q <= 2'h0;
                        state_q <= ST_WR_PUSH;
                    end
                end
                ST_WR_PUSH: begin
                    if (push_fire) begin
                        if (sub_q == 2'h0) begin
                            state_q <= ST_WR_PROG;
                        end else begin
                            addr_q <= addr_q + 16'h0001;
                            crc_q <= `SWRID_CRC_INIT;
                            sub_q <= 2'h2;
                        end
                    end else if (sub_q == 2'h2 && drained) begin
                        // Readback leaves first, or its read slots would be taken as the next data byte
                        state_q <= ST_WR_DATA;
                    end
                end
                ST_WR_PROG: begin
                    // Program only on a fresh voltage pulse, after normal-level traffic
                    if (prog_edge) begin
                        sub_q <= 2'h1;
                        state_q <= ST_WR_PUSH;
                        if (cmd_q == `SWRID_CMD_WRITE_PROT) begin
                            prot_q <= prot_q & data_q[3:0];
                            echo_q <= {4'h0, prot_q & data_q[3:0]};
                        end else if (!in_range) begin
                            echo_q <= `SWRID_ERASED;
                        end else if (page_open) begin
                            mem_q[addr_q[6:0]] <= mem_q[addr_q[6:0]] & data_q;
                            echo_q <= mem_q[addr_q[6:0]] & data_q;
                        end else begin
                            echo_q <= mem_q[addr_q[6:0]];
                        end
                    end
                end
                ST_DEAD: begin
                    state_q <= ST_DEAD;
                end
                default: begin
                    state_q <= ST_DEAD;
                end
            endcase
        end
    end
endmodule

// *** common/swrid_map.vh ***
// Constants for the single-wire identity front end and its byte FIFO.
// Assumes inclusion by bare name from every file in core/.
//
// Summary of operation
// - Identity is 64 bits: family byte, 48-bit serial, check byte over the first 56.
// - Family code is a fixed byte in the lowest byte of the identity.
// - Memory commands are refused until a ROM command completes after bus reset.
// - After a ROM command only read memory, write memory and write protection codes are accepted.
// - Check byte uses generator x^8 + x^5 + x^4 + 1.
// - CRC accumulator starts from zero before the first bit.
// - CRC takes one bit at a time, family first LSB first, then serial.
// - Shifting in the stored check byte too leaves zero.
// - Every byte on the line travels least significant bit first.
// - Programming only clears ones to zeros; zeros never return to one. The core's RESET_N_I reloads every byte and protection bit with ones.
// - Sensing programming voltage raises an internal indication that gates programming.
// - ROM commands use the identity to select one device or search the line.
// - Memory is four 256-bit pages, each protectable against further programming.
// - Whole memory may be programmed then protected, or appended session by session.
// - Read data memory uses code F0h and streams from the given address.
`ifndef SWRID_MAP_VH
`define SWRID_MAP_VH

// ---------------------------------------------------------------
// CRC
// ---------------------------------------------------------------
`define SWRID_CRC_POLY 8'h8C
`define SWRID_CRC_INIT 8'h00

// ---------------------------------------------------------------
// Identity layout
// ---------------------------------------------------------------
`define SWRID_ID_BITS 64
`define SWRID_ID_BYTES 4'h8
`define SWRID_ID_LAST_BIT 6'h3F
`define SWRID_FAMILY_DEFAULT 8'h5A
`define SWRID_SERIAL_DEFAULT 48'h0000_0000_0001

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define SWRID_ROM_READ 8'h01
`define SWRID_ROM_MATCH 8'h02
`define SWRID_ROM_SEARCH 8'h03
`define SWRID_ROM_SKIP 8'h04
`define SWRID_CMD_READ_MEM 8'hF0
`define SWRID_CMD_WRITE_MEM 8'h0F
`define SWRID_CMD_WRITE_PROT 8'h5A

// ---------------------------------------------------------------
// Memory
// ---------------------------------------------------------------
`define SWRID_MEM_BYTES 128
`define SWRID_MEM_END 16'h0080
`define SWRID_ERASED 8'hFF
`define SWRID_PAGES 4
`define SWRID_PROT_RESET 4'hF
`define SWRID_PAGE_MSB 6
`define SWRID_PAGE_LSB 5

// ---------------------------------------------------------------
// FIFO
// ---------------------------------------------------------------
`define SWRID_FIFO_WIDTH 8
`define SWRID_FIFO_DEPTH 16
`define SWRID_FIFO_AW 4

`endif

// *** core/swrid_fifo.v ***
// Byte FIFO between the memory/identity producer and the bit transmitter.
// Assumes one clock; flush empties it in one edge.
`timescale 1ns/10ps
`include "swrid_map.vh"

module swrid_fifo #(
    parameter WIDTH = `SWRID_FIFO_WIDTH,
    parameter DEPTH = `SWRID_FIFO_DEPTH,
    parameter AW = `SWRID_FIFO_AW
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire flush_i,
    input wire in_valid_i,
    input wire [WIDTH-1:0] in_data_i,
    output wire in_ready_o,
    output wire out_valid_o,
    output wire [WIDTH-1:0] out_data_o,
    input wire out_ready_i
);
    reg [WIDTH-1:0] buf_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o = buf_q[rd_q];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (push) begin
            buf_q[wr_q] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// *** testbench/swrid_checker.sv ***
// Port assertions for the identity front end.
// Assumes slots come at least four cycles apart.
`timescale 1ns/10ps
`include "swrid_map.vh"
module swrid_checker (
    input wire CORE_CLK_I,
    input wire RESET_N_I,
    input wire BUS_RESET_I,
    input wire SLOT_I,
    input wire SLOT_BIT_I,
    input wire PROG_SENSE_I,
    input wire TX_BIT_O,
    input wire PROG_DETECT_O,
    input wire ROM_DONE_O
);
    logic [7:0] cnt_q;
    logic [7:0] cmd_q;
    wire got_cmd = (cnt_q == 8'h08);
    wire bad_cmd = (cmd_q < `SWRID_ROM_READ) || (cmd_q > `SWRID_ROM_SKIP);
    // Saturates so a long data phase never wraps into a false command
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cnt_q <= 8'h00;
            cmd_q <= 8'h00;
        end else if (BUS_RESET_I) begin
            cnt_q <= 8'h00;
        end else if (SLOT_I && cnt_q != 8'hFF) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q < 8'h08) begin
                cmd_q <= {SLOT_BIT_I, cmd_q[7:1]};
            end
        end
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_flushed;
        BUS_RESET_I ##1 !SLOT_I [*3];
    endsequence
    sequence s_skip_taken;
        $rose(got_cmd) && cmd_q == `SWRID_ROM_SKIP;
    endsequence
    a_prog_rise_seen: assert property ($rose(PROG_SENSE_I) |-> ##[1:3] PROG_DETECT_O)
        else $error("prog detect late");
    a_prog_quiet_low: assert property (!PROG_SENSE_I [*4] |-> !PROG_DETECT_O)
        else $error("prog detect without voltage");
    a_bus_reset_clears: assert property (BUS_RESET_I |=> !ROM_DONE_O)
        else $error("rom done kept over bus reset");
    a_done_needs_cmd: assert property ($rose(ROM_DONE_O) |-> cnt_q >= 8'h08)
        else $error("rom done before a command");
    a_done_level_holds: assert property (ROM_DONE_O && !BUS_RESET_I |=> ROM_DONE_O)
        else $error("rom done dropped");
    a_tx_released: assert property (s_flushed |-> TX_BIT_O)
        else $error("line held after bus reset");
    a_skip_enables_mem: assert property (s_skip_taken |-> ##[0:2] ROM_DONE_O)
        else $error("skip did not enable memory");
    a_bad_cmd_dead: assert property (cnt_q >= 8'h08 && bad_cmd && !BUS_RESET_I |-> !ROM_DONE_O && TX_BIT_O)
        else $error("unknown rom command not refused");
endmodule

bind swrid_core swrid_checker u_chk (
    .CORE_CLK_I(CORE_CLK_I),
    .RESET_N_I(RESET_N_I),
    .BUS_RESET_I(BUS_RESET_I),
    .SLOT_I(SLOT_I),
    .SLOT_BIT_I(SLOT_BIT_I),
    .PROG_SENSE_I(PROG_SENSE_I),
    .TX_BIT_O(TX_BIT_O),
    .PROG_DETECT_O(PROG_DETECT_O),
    .ROM_DONE_O(ROM_DONE_O)
);

// *** testbench/swrid_master_model.sv ***
// Bus master stand-in issuing slots to the identity front end.
// Assumes the front end takes a slot on one rising edge.
`timescale 1ns/10ps
module swrid_master_model (
    input wire clk_i,
    input wire tx_bit_i,
    output reg bus_reset_o,
    output reg slot_o,
    output reg slot_bit_o,
    output reg prog_sense_o
);
    initial begin
        bus_reset_o = 1'b0;
        slot_o = 1'b0;
        slot_bit_o = 1'b1;
        prog_sense_o = 1'b0;
    end
    // Five idle cycles after each slot leave the answer time to settle
    task slot(input logic b);
        @(negedge clk_i);
        slot_o = 1'b1;
        slot_bit_o = b;
        @(negedge clk_i);
        slot_o = 1'b0;
        slot_bit_o = 1'b1; // Released line rests high on its pull-up
        repeat (5) @(negedge clk_i);
    endtask
    task bus_reset;
        @(negedge clk_i);
        bus_reset_o = 1'b1;
        @(negedge clk_i);
        bus_reset_o = 1'b0;
    endtask
    task send_byte(input logic [7:0] d);
        for (int i = 0; i < 8; i++) slot(d[i]);
    endtask
    task get_bits(input int n, output logic [63:0] v);
        v = 64'h0;
        for (int i = 0; i < n; i++) begin
            v[i] = tx_bit_i;
            slot(tx_bit_i);
        end
    endtask
    task prog_pulse;
        @(negedge clk_i);
        prog_sense_o = 1'b1;
        repeat (6) @(negedge clk_i);
        prog_sense_o = 1'b0;
        repeat (12) @(negedge clk_i);
    endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the identity front end.
// Assumes the master model drives every slot at a falling edge.
`timescale 1ns/10ps
`include "swrid_map.vh"
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wire bus_rst, slot, sbit, psense, tx, pdet, rdone;
    logic [63:0] v;
    logic [63:0] id;
    logic [7:0] d;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    swrid_core uut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .BUS_RESET_I(bus_rst), .SLOT_I(slot),
        .SLOT_BIT_I(sbit), .PROG_SENSE_I(psense), .TX_BIT_O(tx), .PROG_DETECT_O(pdet), .ROM_DONE_O(rdone));
    swrid_master_model mst (.clk_i(clk), .tx_bit_i(tx), .bus_reset_o(bus_rst), .slot_o(slot),
        .slot_bit_o(sbit), .prog_sense_o(psense));
    function automatic logic [7:0] crc8(input logic [63:0] x, input int n);
        logic [7:0] c = 8'h00;
        for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ x[i]) ? `SWRID_CRC_POLY : 8'h00);
        return c;
    endfunction
    task chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            $display("[FAIL] %0t timeout", $time);
            end_of_test;
        end
    end
    task t_mem_refused;
        mst.bus_reset;
        mst.send_byte(`SWRID_CMD_READ_MEM);
        mst.send_byte(8'h00);
        mst.get_bits(16, v);
        chk({rdone, v[15:0]}, 17'h0FFFF);
    endtask
    task t_read_rom;
        id = {8'h00, `SWRID_SERIAL_DEFAULT, `SWRID_FAMILY_DEFAULT};
        id[63:56] = crc8(id, 56);
        mst.bus_reset;
        mst.send_byte(`SWRID_ROM_READ);
        mst.get_bits(64, v);
        chk(v, id);
        chk(crc8(v, 64), 8'h00);
        chk(rdone, 1'b1);
    endtask
    task t_match_rom;
        mst.bus_reset;
        mst.send_byte(`SWRID_ROM_MATCH);
        for (int k = 0; k < 8; k++) mst.send_byte(id[8*k+:8]);
        chk(rdone, 1'b1);
        mst.bus_reset;
        mst.send_byte(`SWRID_ROM_MATCH);
        mst.send_byte(~id[7:0]);
        mst.get_bits(8, v);
        chk({rdone, v[7:0]}, 9'h0FF);
    endtask
    task t_search_rom;
        mst.bus_reset;
        mst.send_byte(`SWRID_ROM_SEARCH);
        for (int k = 0; k < 64; k++) begin
            mst.get_bits(2, v);
            chk(v[1:0], {~id[k], id[k]});
            mst.slot(id[k]);
        end
        chk(rdone, 1'b1);
    endtask
    task t_write_mem;
        for (int k = 0; k < 2; k++) begin
            d = k ? 8'h5A : 8'hA5;
            mst.bus_reset;
            mst.send_byte(`SWRID_ROM_SKIP);
            mst.send_byte(`SWRID_CMD_WRITE_MEM);
            mst.send_byte(8'h10);
            mst.send_byte(8'h00);
            mst.send_byte(d);
            mst.get_bits(8, v);
            chk(v[7:0], crc8({d, 16'h0010, `SWRID_CMD_WRITE_MEM}, 32));
            mst.prog_pulse;
            mst.get_bits(8, v);
            chk(v[7:0], 8'hA5 & d);
        end
    endtask
    task t_read_mem;
        mst.bus_reset;
        mst.send_byte(`SWRID_ROM_SKIP);
        mst.send_byte(`SWRID_CMD_READ_MEM);
        mst.send_byte(8'h7E);
        mst.send_byte(8'h00);
        mst.get_bits(40, v);
        chk(v[7:0], crc8({16'h007E, `SWRID_CMD_READ_MEM}, 24));
        chk(v[39:8], {8'hFF, crc8(16'hFFFF, 16), 16'hFFFF});
    endtask
    // Closes page 0, then a write into it must read back the untouched byte
    task t_write_prot;
        for (int k = 0; k < 2; k++) begin
            mst.bus_reset;
            mst.send_byte(`SWRID_ROM_SKIP);
            mst.send_byte(k ? `SWRID_CMD_WRITE_MEM : `SWRID_CMD_WRITE_PROT);
            mst.send_byte(k ? 8'h11 : 8'h00);
            mst.send_byte(8'h00);
            mst.send_byte(k ? 8'h00 : 8'h0E);
            mst.get_bits(8, v);
            mst.prog_pulse;
            mst.get_bits(8, v);
            chk(v[7:0], k ? 8'hFF : 8'h0E);
        end
    endtask
    initial begin
        repeat (5) @(negedge clk);
        chk({tx, pdet, rdone}, 3'b100);
        rst_n = 1'b1;
        t_mem_refused;
        t_read_rom;
        t_match_rom;
        t_search_rom;
        t_write_mem;
        t_read_mem;
        t_write_prot;
        end_of_test;
    end
endmodule
